// ===== rtl/gcpm_global_config.sv
// Purpose: Global configuration, pad ownership mux and shared RAM self-test control
// Assumes: core_clk system clock; rst_n is the power-good reset, active low
// Notes:   Pads are modelled as input/output/enable triples
`timescale 1ns/100ps
`default_nettype none
module gcpm_global_config
  import gcpm_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Peripheral register bus
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [7:0]  pwdata,
  output logic      [7:0]  prdata,
  input  wire logic        apb_any_write,
  // Strap pads
  input  wire logic [22:17] strap_addr_pads,
  // Clock sources
  input  wire logic        synth_clk,
  input  wire logic        master_clock_input_pad,
  input  wire logic        synth_locked,
  output logic             sys_clk_out,
  output logic             usb_clk_enable,
  output logic             parallel_port_clk_enable,
  output logic             parallel_port_mapped,
  output logic             boot_bank_16bit,
  output logic [7:0]       hw_cfg,
  // Shared parallel/memory pads: 8 data, 10 control
  input  wire logic [17:0] shared_port_pads_in,
  output logic      [17:0] shared_port_pads_out,
  output logic      [17:0] shared_port_pads_oe,
  input  wire logic [17:0] shmem_pads_out,
  input  wire logic [17:0] shmem_pads_oe,
  output logic      [17:0] shmem_pads_in,
  input  wire logic [17:0] parallel_port_pads_out,
  input  wire logic [17:0] parallel_port_pads_oe,
  output logic      [17:0] parallel_port_pads_in,
  // Debug-shared pads: ext_io_bank_select, rom_bank_select, dram_row_strobe[2:0]
  input  wire logic [4:0]  dbg_pads_in,
  output logic      [4:0]  dbg_pads_out,
  output logic      [4:0]  dbg_pads_oe,
  input  wire logic        ext_io_bank_select,
  input  wire logic        rom_bank_select,
  input  wire logic [2:0]  dram_row_strobe,
  output logic             jtag_tck,
  output logic             jtag_tms,
  output logic             jtag_tdi,
  input  wire logic        jtag_tdo,
  output logic             jtag_trst_n,
  // GPIO pads and two extra address pads
  input  wire logic [5:0]  gpio_pads_in,
  output logic      [5:0]  gpio_pads_out,
  output logic      [5:0]  gpio_pads_oe,
  input  wire logic [5:0]  gpio_blk_out,
  input  wire logic [5:0]  gpio_blk_oe,
  output logic      [5:0]  gpio_blk_in,
  input  wire logic [5:0]  usb_xcvr_out,
  input  wire logic [5:0]  usb_xcvr_oe,
  output logic      [5:0]  usb_xcvr_in,
  input  wire logic [1:0]  xaddr_pads_in,
  output logic      [1:0]  xaddr_pads_out,
  output logic      [1:0]  xaddr_pads_oe,
  input  wire logic [1:0]  shmem_xaddr_out,
  output logic      [1:0]  usb_vp_vm,
  input  wire logic        i2c_scl_drive_low,
  input  wire logic        i2c_sda_drive_low,
  output logic             i2c_scl_in,
  output logic             i2c_sda_in,
  // Self-test engine
  output logic             selftest_start,
  output logic             shared_mem_chip_disable,
  input  wire logic        selftest_finished,
  input  wire logic        selftest_pass_fail,
  input  wire logic        selftest_procedure_fault
);
  import gcpm_pkg::*;

  // ----------------------------------------
  // Strap capture
  // ----------------------------------------
  logic [22:17] strap_reg;
  logic [7:0]   pad_ctrl_reg;
  logic [7:0]   st_ctrl_reg;
  logic [7:0]   st_status_reg;
  logic [7:0]   lock_reg;
  logic         unlocked_reg;
  logic         lock_meta_reg;

  // Straps follow the pads on every edge while reset is low and freeze when it releases
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      strap_reg <= strap_addr_pads;
  end

  logic debug_mode_n;
  logic bypass;
  // Debug and bypass follow the pad during reset, so they act before any clock
  assign debug_mode_n = rst_n ? strap_reg[GCPM_STRAP_DEBUG]  : strap_addr_pads[GCPM_STRAP_DEBUG];
  assign bypass       = rst_n ? strap_reg[GCPM_STRAP_BYPASS] : strap_addr_pads[GCPM_STRAP_BYPASS];

  assign hw_cfg = {strap_reg[22:17], 2'h0};

  // ----------------------------------------
  // Clock and configuration outputs
  // ----------------------------------------
  assign usb_clk_enable           = strap_reg[GCPM_STRAP_USB_CLK];
  assign parallel_port_clk_enable = strap_reg[GCPM_STRAP_PARPORT];
  assign parallel_port_mapped     = strap_reg[GCPM_STRAP_PARPORT];
  assign boot_bank_16bit          = strap_reg[GCPM_STRAP_BOOTW];
  assign sys_clk_out              = bypass ? master_clock_input_pad : synth_clk;

  // ----------------------------------------
  // Shared parallel / memory pads
  // ----------------------------------------
  always_comb
  begin
    if (strap_reg[GCPM_STRAP_PARPORT])
    begin
      shared_port_pads_out = parallel_port_pads_out;
      shared_port_pads_oe  = parallel_port_pads_oe;
    end
    else
    begin
      shared_port_pads_out = shmem_pads_out;
      shared_port_pads_oe  = shmem_pads_oe;
    end
  end
  assign parallel_port_pads_in = strap_reg[GCPM_STRAP_PARPORT] ? shared_port_pads_in : 18'h00000;
  assign shmem_pads_in         = strap_reg[GCPM_STRAP_PARPORT] ? 18'h00000 : shared_port_pads_in;

  // ----------------------------------------
  // Debug port pads
  // ----------------------------------------
  always_comb
  begin
    if (debug_mode_n)
    begin
      dbg_pads_out = {dram_row_strobe, rom_bank_select, ext_io_bank_select};
      dbg_pads_oe  = 5'h1F;
    end
    else
    begin
      dbg_pads_out = {1'b0, jtag_tdo, 3'h0};
      dbg_pads_oe  = 5'h08;
    end
  end
  assign jtag_tck    = debug_mode_n ? 1'b0 : dbg_pads_in[0];
  assign jtag_tms    = debug_mode_n ? 1'b0 : dbg_pads_in[1];
  assign jtag_tdi    = debug_mode_n ? 1'b0 : dbg_pads_in[2];
  assign jtag_trst_n = debug_mode_n ? 1'b1 : dbg_pads_in[4];

  // ----------------------------------------
  // GPIO / USB transceiver / I2C pads
  // ----------------------------------------
  logic usb_ext;
  logic two_wire_off;
  assign two_wire_off = pad_ctrl_reg[GCPM_TWO_WIRE_BIT];
  assign usb_ext      = pad_ctrl_reg[GCPM_USB_EXT_BIT];

  always_comb
  begin
    if (usb_ext)
    begin
      gpio_pads_out  = usb_xcvr_out;
      gpio_pads_oe   = usb_xcvr_oe;
      xaddr_pads_out = 2'h0;
      xaddr_pads_oe  = 2'h0;
    end
    else
    begin
      gpio_pads_out  = gpio_blk_out;
      gpio_pads_oe   = gpio_blk_oe;
      xaddr_pads_out = shmem_xaddr_out;
      xaddr_pads_oe  = 2'h3;
    end
    if (!two_wire_off)
    begin
      gpio_pads_out[5:4] = 2'h0;
      gpio_pads_oe[4]    = i2c_scl_drive_low;
      gpio_pads_oe[5]    = i2c_sda_drive_low;
    end
  end
  assign usb_xcvr_in = usb_ext ? gpio_pads_in : 6'h00;
  assign gpio_blk_in = usb_ext ? 6'h00 : gpio_pads_in;
  assign usb_vp_vm   = usb_ext ? xaddr_pads_in : 2'h0;
  assign i2c_scl_in  = two_wire_off ? 1'b1 : gpio_pads_in[4];
  assign i2c_sda_in  = two_wire_off ? 1'b1 : gpio_pads_in[5];

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pad_ctrl_reg <= GCPM_REG_RESET;
    else if (wr_acc && paddr == GCPM_PAD_CONTROL_ADDR)
      pad_ctrl_reg <= {6'h00, pwdata[1:0]};
  end

  // Protection: key write unlocks, any other bus write re-arms
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      unlocked_reg <= 1'b0;
    else if (wr_acc && paddr == GCPM_ST_CONTROL_ADDR && pwdata == GCPM_UNLOCK_KEY && !unlocked_reg)
      unlocked_reg <= 1'b1;
    else if (wr_acc || apb_any_write)
      unlocked_reg <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ctrl_reg <= GCPM_REG_RESET;
    else if (wr_acc && paddr == GCPM_ST_CONTROL_ADDR && unlocked_reg)
      st_ctrl_reg <= {6'h00, pwdata[1:0]};
  end
  assign selftest_start          = st_ctrl_reg[GCPM_START_BIT];
  assign shared_mem_chip_disable = st_ctrl_reg[GCPM_CHIP_DIS_BIT];

  // Completion flags latch; a new start clears them
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_status_reg <= GCPM_REG_RESET;
    else if (selftest_finished)
      st_status_reg <= {5'h00, selftest_procedure_fault, selftest_pass_fail, 1'b1};
    else if (wr_acc && paddr == GCPM_ST_CONTROL_ADDR && unlocked_reg && pwdata[GCPM_START_BIT])
      st_status_reg <= GCPM_REG_RESET;
  end

  // Lock input comes from the analog synthesizer, so synchronise it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lock_meta_reg <= 1'b0;
      lock_reg      <= GCPM_REG_RESET;
    end
    else
    begin
      lock_meta_reg <= synth_locked;
      lock_reg      <= {7'h00, lock_meta_reg};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= GCPM_REG_RESET;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        GCPM_HW_CFG_ADDR:      prdata <= hw_cfg;
        GCPM_PAD_CONTROL_ADDR: prdata <= pad_ctrl_reg;
        GCPM_LOCK_STATUS_ADDR: prdata <= lock_reg;
        GCPM_ST_CONTROL_ADDR:  prdata <= st_ctrl_reg;
        GCPM_ST_STATUS_ADDR:   prdata <= st_status_reg;
        default:               prdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_protect_ignores;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_acc && paddr == GCPM_ST_CONTROL_ADDR && !unlocked_reg) |=> $stable(st_ctrl_reg);
  endproperty
  a_protect_ignores: assert property (p_protect_ignores) else $error("locked write changed test control");

  property p_rearm;
    @(posedge core_clk) disable iff (!rst_n)
      (unlocked_reg && (wr_acc || apb_any_write)) |=> !unlocked_reg;
  endproperty
  a_rearm: assert property (p_rearm) else $error("protection not re-armed");

  property p_start_drives;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_acc && paddr == GCPM_ST_CONTROL_ADDR && unlocked_reg) |=>
        selftest_start == $past(pwdata[GCPM_START_BIT]);
  endproperty
  a_start_drives: assert property (p_start_drives) else $error("start output mismatch");

  property p_chip_disable;
    @(posedge core_clk) disable iff (!rst_n)
      (wr_acc && paddr == GCPM_ST_CONTROL_ADDR && unlocked_reg) |=>
        shared_mem_chip_disable == $past(pwdata[GCPM_CHIP_DIS_BIT]);
  endproperty
  a_chip_disable: assert property (p_chip_disable) else $error("chip select not disabled");

  property p_done_sets;
    @(posedge core_clk) disable iff (!rst_n)
      selftest_finished |=> st_status_reg[0] && st_status_reg[1] == $past(selftest_pass_fail)
        && st_status_reg[2] == $past(selftest_procedure_fault);
  endproperty
  a_done_sets: assert property (p_done_sets) else $error("status not captured");

  property p_lock_follow;
    @(posedge core_clk) disable iff (!rst_n)
      synth_locked [*3] |-> lock_reg[0];
  endproperty
  a_lock_follow: assert property (p_lock_follow) else $error("lock status lags");

  property p_i2c_pads;
    @(posedge core_clk) disable iff (!rst_n)
      !two_wire_off |-> gpio_pads_oe[4] == i2c_scl_drive_low && gpio_pads_out[4] == 1'b0;
  endproperty
  a_i2c_pads: assert property (p_i2c_pads) else $error("I2C pad not open drain");

  property p_usb_ext;
    @(posedge core_clk) disable iff (!rst_n)
      (usb_ext && two_wire_off) |-> gpio_pads_out == usb_xcvr_out && xaddr_pads_oe == 2'h0;
  endproperty
  a_usb_ext: assert property (p_usb_ext) else $error("USB pads not routed");

  c_unlock_write: cover property (@(posedge core_clk) disable iff (!rst_n)
    unlocked_reg && wr_acc && paddr == GCPM_ST_CONTROL_ADDR);
  c_selftest_done: cover property (@(posedge core_clk) disable iff (!rst_n) selftest_finished);
  c_usb_mode: cover property (@(posedge core_clk) disable iff (!rst_n) usb_ext && two_wire_off);
endmodule
`default_nettype wire

// ===== rtl/gcpm_pkg.sv
// Purpose: Constants for the global configuration and pad mux block
// Assumes: APB-style register access, 8-bit registers on 32-bit aligned words
// Notes:   Offsets are full byte addresses
package gcpm_pkg;
  localparam logic [31:0] GCPM_PAD_CONTROL_ADDR  = 32'h30001C08;
  localparam logic [31:0] GCPM_LOCK_STATUS_ADDR  = 32'h30001C0C;
  localparam logic [31:0] GCPM_ST_CONTROL_ADDR   = 32'h30001C10;
  localparam logic [31:0] GCPM_ST_STATUS_ADDR    = 32'h30001C14;
  localparam logic [31:0] GCPM_HW_CFG_ADDR       = 32'h30001C04;
  localparam logic [7:0]  GCPM_REG_RESET         = 8'h00;
  localparam logic [7:0]  GCPM_UNLOCK_KEY        = 8'h45;
  // Field positions
  localparam int GCPM_TWO_WIRE_BIT  = 0;
  localparam int GCPM_USB_EXT_BIT   = 1;
  localparam int GCPM_CHIP_DIS_BIT  = 0;
  localparam int GCPM_START_BIT     = 1;
  localparam int GCPM_FINISH_BIT    = 0;
  localparam int GCPM_PASS_BIT      = 1;
  localparam int GCPM_FAULT_BIT     = 2;
  // Strap pad positions within the address pad bus
  localparam int GCPM_STRAP_USB_CLK = 21;
  localparam int GCPM_STRAP_PARPORT = 20;
  localparam int GCPM_STRAP_BOOTW   = 19;
  localparam int GCPM_STRAP_DEBUG   = 18;
  localparam int GCPM_STRAP_BYPASS  = 17;
endpackage

// ===== tb/gcpm_selftest_model.sv
// Purpose: Stand-in for the shared memory self-test engine
// Assumes: Runs on the block clock; a run lasts LAT cycles after start goes high
// Notes:   Result lines carry toggling junk until the run has finished
`timescale 1ns/100ps
`default_nettype none
module gcpm_selftest_model #(
  parameter int LAT = 8
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Engine control and chosen outcome
  input  wire logic selftest_start,
  input  wire logic want_pass,
  input  wire logic want_fault,
  // Engine results
  output logic      finished,
  output logic      pass_fail,
  output logic      procedure_fault
);
  int cnt;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= 0;
    else if (!selftest_start)
      cnt <= 0;
    else if (cnt < LAT)
      cnt <= cnt + 1;
  end
  // Junk results must not be mistaken for a finished run
  assign finished        = (cnt == LAT);
  assign pass_fail       = finished ? want_pass : cnt[0];
  assign procedure_fault = finished ? want_fault : ~cnt[0];
endmodule
`default_nettype wire

// ===== tb/test_global_config_pin_mux.sv
// Purpose: Self-checking bench for the global configuration and pad mux block
// Assumes: Register model below mirrors straps, lock and self-test results
// Notes:   Pad sources are randomised before every mux check
`timescale 1ns/100ps
`default_nettype none
module test_global_config_pin_mux;
  import gcpm_pkg::*;
  logic core_clk, rst_n, psel, penable, pwrite, apb_any_write, synth_locked, unlocked, m_lock;
  logic synth_clk, master_clock_input_pad, sys_clk_out, usb_clk_enable, boot_bank_16bit;
  logic parallel_port_clk_enable, parallel_port_mapped, ext_io_bank_select, rom_bank_select;
  logic jtag_tck, jtag_tms, jtag_tdi, jtag_tdo, jtag_trst_n, i2c_scl_drive_low, i2c_sda_drive_low;
  logic i2c_scl_in, i2c_sda_in, selftest_start, shared_mem_chip_disable, want_pass, want_fault;
  logic selftest_finished, selftest_pass_fail, selftest_procedure_fault;
  logic [31:0] paddr;
  logic [7:0] pwdata, prdata, hw_cfg, m_pad, m_ctrl, m_stat;
  logic [22:17] strap_addr_pads, s_lat;
  logic [17:0] shared_port_pads_in, shared_port_pads_out, shared_port_pads_oe, shmem_pads_out;
  logic [17:0] shmem_pads_oe, parallel_port_pads_out, parallel_port_pads_oe;
  logic [17:0] shmem_pads_in, parallel_port_pads_in;
  logic [4:0] dbg_pads_in, dbg_pads_out, dbg_pads_oe;
  logic [2:0] dram_row_strobe;
  logic [5:0] gpio_pads_in, gpio_pads_out, gpio_pads_oe, gpio_blk_out, gpio_blk_oe;
  logic [5:0] usb_xcvr_out, usb_xcvr_oe, pad_pull, gpio_blk_in, usb_xcvr_in;
  logic [1:0] xaddr_pads_in, xaddr_pads_out, shmem_xaddr_out, usb_vp_vm, xaddr_pads_oe;
  logic [159:0] src;
  int num_errors = 0;
  int tests_run = 0;

  assign {shared_port_pads_in, shmem_pads_out, shmem_pads_oe, parallel_port_pads_out,
          parallel_port_pads_oe, dbg_pads_in, ext_io_bank_select, rom_bank_select,
          dram_row_strobe, jtag_tdo, pad_pull, gpio_blk_out, gpio_blk_oe, usb_xcvr_out,
          usb_xcvr_oe, xaddr_pads_in, shmem_xaddr_out, i2c_scl_drive_low, i2c_sda_drive_low,
          synth_clk, master_clock_input_pad} = src[138:0];
  // Driven pads follow their driver, released ones the board pull
  assign gpio_pads_in = (gpio_pads_oe & gpio_pads_out) | (~gpio_pads_oe & pad_pull);

  gcpm_global_config i_dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .apb_any_write, .strap_addr_pads, .synth_clk, .master_clock_input_pad,
    .synth_locked, .sys_clk_out, .usb_clk_enable, .parallel_port_clk_enable,
    .parallel_port_mapped, .boot_bank_16bit, .hw_cfg, .shared_port_pads_in,
    .shared_port_pads_out, .shared_port_pads_oe, .shmem_pads_out, .shmem_pads_oe,
    .shmem_pads_in, .parallel_port_pads_out, .parallel_port_pads_oe,
    .parallel_port_pads_in, .dbg_pads_in, .dbg_pads_out, .dbg_pads_oe, .ext_io_bank_select,
    .rom_bank_select, .dram_row_strobe, .jtag_tck, .jtag_tms, .jtag_tdi, .jtag_tdo,
    .jtag_trst_n, .gpio_pads_in, .gpio_pads_out, .gpio_pads_oe, .gpio_blk_out, .gpio_blk_oe,
    .gpio_blk_in, .usb_xcvr_out, .usb_xcvr_oe, .usb_xcvr_in, .xaddr_pads_in,
    .xaddr_pads_out, .xaddr_pads_oe, .shmem_xaddr_out, .usb_vp_vm, .i2c_scl_drive_low,
    .i2c_sda_drive_low, .i2c_scl_in, .i2c_sda_in, .selftest_start, .shared_mem_chip_disable,
    .selftest_finished, .selftest_pass_fail, .selftest_procedure_fault);

  gcpm_selftest_model #(.LAT(8)) i_engine (.core_clk, .rst_n, .selftest_start, .want_pass,
    .want_fault, .finished(selftest_finished), .pass_fail(selftest_pass_fail),
    .procedure_fault(selftest_procedure_fault));

  // ------------------------------------------------------------
  // Clock, checking and bus tasks
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input string nm, input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge core_clk);
    psel = 1'h1;
    pwrite = w;
    paddr = a;
    pwdata = d;
    @(negedge core_clk);
    penable = 1'h1;
    @(negedge core_clk);
    q = prdata;
    psel = 1'h0;
    penable = 1'h0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'h1, a, d, q);
    if (a == GCPM_PAD_CONTROL_ADDR)
      m_pad = d & 8'h03;
    if (a == GCPM_ST_CONTROL_ADDR && unlocked)
    begin
      m_ctrl = d & 8'h03;
      if (d[1])
        m_stat = 8'h00;
    end
    unlocked = (a == GCPM_ST_CONTROL_ADDR) && (d == GCPM_UNLOCK_KEY) && !unlocked;
    chk("selftest_pins", {selftest_start, shared_mem_chip_disable}, m_ctrl[1:0]);
  endtask

  task automatic rd(input logic [31:0] a);
    logic [7:0] q;
    logic [7:0] e;
    bus(1'h0, a, 8'h00, q);
    case (a)
      GCPM_PAD_CONTROL_ADDR: e = m_pad;
      GCPM_LOCK_STATUS_ADDR: e = {7'h00, m_lock};
      GCPM_ST_CONTROL_ADDR:  e = m_ctrl;
      GCPM_ST_STATUS_ADDR:   e = m_stat;
      GCPM_HW_CFG_ADDR:      e = {s_lat, 2'h0};
      default:               e = 8'h00;
    endcase
    chk("prdata", q, e);
  endtask

  task automatic do_reset();
    logic [1:0] e;
    @(negedge core_clk);
    rst_n = 1'h0;
    s_lat = strap_addr_pads;
    {m_pad, m_ctrl, m_stat, m_lock, unlocked} = '0;
    src = {$urandom, $urandom, $urandom, $urandom, $urandom};
    #10;
    // Bypass and debug straps act straight from the pads while reset is low
    e[1] = strap_addr_pads[17] ? master_clock_input_pad : synth_clk;
    e[0] = strap_addr_pads[18] ? 1'h0 : dbg_pads_in[0];
    chk("rst_straps", {sys_clk_out, jtag_tck}, e);
    repeat (2) @(negedge core_clk);
    rst_n = 1'h1;
  endtask

  task automatic check_mux();
    logic [5:0] eo;
    logic [5:0] ee;
    src = {$urandom, $urandom, $urandom, $urandom, $urandom};
    #10;
    eo = m_pad[1] ? usb_xcvr_out : gpio_blk_out;
    ee = m_pad[1] ? usb_xcvr_oe : gpio_blk_oe;
    if (!m_pad[0])
    begin
      eo[5:4] = 2'h0;
      ee[5:4] = {i2c_sda_drive_low, i2c_scl_drive_low};
      chk("i2c_in", {i2c_sda_in, i2c_scl_in}, gpio_pads_in[5:4]);
    end
    chk("gpio_out", gpio_pads_out, eo);
    chk("gpio_oe", gpio_pads_oe, ee);
    if (m_pad[1])
      chk("vp_vm", usb_vp_vm, xaddr_pads_in);
    else
      chk("xaddr_out", xaddr_pads_out, shmem_xaddr_out);
    chk("xaddr_oe", xaddr_pads_oe, m_pad[1] ? 2'h0 : 2'h3);
    chk("gpio_in", m_pad[1] ? usb_xcvr_in : gpio_blk_in, gpio_pads_in);
    chk("usb_clk", usb_clk_enable, s_lat[21]);
    chk("pport", {parallel_port_clk_enable, parallel_port_mapped}, {2{s_lat[20]}});
    chk("shared_out", shared_port_pads_out, s_lat[20] ? parallel_port_pads_out : shmem_pads_out);
    chk("shared_oe", shared_port_pads_oe, s_lat[20] ? parallel_port_pads_oe : shmem_pads_oe);
    chk("shared_in", s_lat[20] ? parallel_port_pads_in : shmem_pads_in, shared_port_pads_in);
    chk("dbg_oe", dbg_pads_oe, s_lat[18] ? 5'h1F : 5'h08);
    chk("boot16", boot_bank_16bit, s_lat[19]);
    if (s_lat[18])
      chk("dbg_out", dbg_pads_out, {dram_row_strobe, rom_bank_select, ext_io_bank_select});
    else
      chk("jtag", {jtag_trst_n, jtag_tdi, jtag_tms, jtag_tck, dbg_pads_out[3]},
          {dbg_pads_in[4], dbg_pads_in[2:0], jtag_tdo});
    chk("sys_clk", sys_clk_out, s_lat[17] ? master_clock_input_pad : synth_clk);
    chk("hw_cfg", hw_cfg, {s_lat, 2'h0});
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(11879));
    rst_n = 1'h0;
    {psel, penable, pwrite, apb_any_write, synth_locked, want_pass, want_fault} = '0;
    {paddr, pwdata, strap_addr_pads, src} = '0;
    for (int p = 0; p < 2; p++)
    begin
      strap_addr_pads = 6'($urandom);
      do_reset();
      strap_addr_pads = ~strap_addr_pads;
      check_mux();
      for (int a = 0; a < 6; a++)
        rd(GCPM_HW_CFG_ADDR + 32'(a * 4));
    end
    for (int v = 0; v < 4; v++)
      if (v != 2)
      begin
        wr(GCPM_PAD_CONTROL_ADDR, 8'hFC | 8'(v));
        rd(GCPM_PAD_CONTROL_ADDR);
        check_mux();
      end
    synth_locked = 1'h1;
    repeat (3) @(negedge core_clk);
    m_lock = 1'h1;
    rd(GCPM_LOCK_STATUS_ADDR);
    wr(GCPM_ST_CONTROL_ADDR, 8'h03);
    wr(GCPM_ST_CONTROL_ADDR, GCPM_UNLOCK_KEY);
    wr(GCPM_ST_CONTROL_ADDR, 8'h01);
    wr(GCPM_ST_CONTROL_ADDR, GCPM_UNLOCK_KEY);
    @(negedge core_clk);
    apb_any_write = 1'h1;
    @(negedge core_clk);
    apb_any_write = 1'h0;
    unlocked = 1'h0;
    wr(GCPM_ST_CONTROL_ADDR, 8'h02);
    rd(GCPM_ST_CONTROL_ADDR);
    for (int r = 0; r < 2; r++)
    begin
      {want_pass, want_fault} = 2'($urandom);
      wr(GCPM_ST_CONTROL_ADDR, GCPM_UNLOCK_KEY);
      wr(GCPM_ST_CONTROL_ADDR, 8'h02);
      rd(GCPM_ST_STATUS_ADDR);
      repeat (12) @(negedge core_clk);
      m_stat = {5'h00, want_fault, want_pass, 1'h1};
      rd(GCPM_ST_STATUS_ADDR);
      wr(GCPM_ST_CONTROL_ADDR, GCPM_UNLOCK_KEY);
      wr(GCPM_ST_CONTROL_ADDR, 8'h00);
    end
    conclude();
  end

  initial
  begin
    #200000;
    num_errors++;
    conclude();
  end
endmodule
`default_nettype wire
